// File: src/arb_pkg.sv
// Constants, register map and state types for the PCI arbiter and shared frame buffer decode.
// Assumes a single 40 MHz clock that serves as both PCI and host clock.
package arb_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int GNT_TIMEOUT_PCLKS = 16;
	localparam logic [4:0] GNT_TIMEOUT_PRESET = 5'(GNT_TIMEOUT_PCLKS - 1);
	localparam int TMR_W             = 8;
	localparam int GTO_W             = 5;

	// ----------------------------------------------------------------
	// Agents
	// ----------------------------------------------------------------
	localparam int N_AGENTS  = 5;
	localparam logic [2:0] AGENT_GFX  = 3'h3;
	localparam logic [2:0] AGENT_ISA  = 3'h4;
	localparam logic [2:0] AGENT_LAST = 3'h4;
	localparam logic [1:0] HOST_AFTER_MODE0 = 2'h3;
	localparam logic [1:0] HOST_AFTER_MODE1 = 2'h2;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_ARB_CTRL   = 8'h00;
	localparam logic [7:0] ADR_SB_CTRL    = 8'h04;
	localparam logic [7:0] ADR_SB_START   = 8'h08;
	localparam logic [7:0] ADR_ROW_BND4   = 8'h0c;
	localparam logic [7:0] ADR_RELOC_BASE = 8'h10;
	localparam logic [7:0] ADR_RELOC_LIM  = 8'h14;
	localparam logic [7:0] ADR_STATUS     = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int ARB_SCHEME_BIT = 0;
	localparam int MTT_LSB        = 8;
	localparam int HLT_LSB        = 16;
	localparam int SB_APERTURE_BIT = 0;
	localparam int SB_ENABLE_BIT   = 1;
	localparam int SB_OVERLAP_BIT  = 2;
	localparam int SB_HOLE_EN_BIT  = 3;
	localparam int SB_HOLE_2MB_BIT = 4;
	localparam int SB_RELOC_EN_BIT = 5;
	localparam int MB_W            = 12;
	localparam int MB_LSB          = 20;
	localparam int ST_GFX_BIT      = 6;
	localparam int ST_CNT_LSB      = 8;
	localparam logic [31:0] ARB_CTRL_RST = 32'h0010_1000;
	localparam logic [31:0] SB_CTRL_RST  = 32'h0000_0000;
	localparam logic [MB_W-1:0] MB_RST   = 12'h000;
	localparam logic [MB_W-1:0] HOLE_TOP_MB  = 12'h010;
	localparam logic [MB_W-1:0] HOLE_1MB_BOT = 12'h00f;
	localparam logic [MB_W-1:0] HOLE_2MB_BOT = 12'h00e;

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_GRANT, ST_BUSY, ST_HOST} arb_state_t;
	typedef enum logic [1:0] {GFX_PARK, GFX_PEND, GFX_OWN} gfx_state_t;

endpackage : arb_pkg

// File: src/countdown_if.sv
// Load and count signals between the arbiter and one of its down counters.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface countdown_if #(parameter int W = 8);
	logic         load;
	logic [W-1:0] preset;
	logic [W-1:0] count;
	logic         zero;
	modport ctrl  (output load, output preset, input count, input zero);
	modport timer (input load, input preset, output count, output zero);
endinterface : countdown_if

// File: src/countdown_timer.sv
// A down counter that loads a preset and counts to zero, one step per clock.
// Assumes a synchronous active-high reset.
`timescale 1ns/10ps
module countdown_timer #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	// Counter signals
	countdown_if.timer t
);
	logic [W-1:0] count_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_ff <= '0;
		end else if (t.load) begin
			count_ff <= t.preset;
		end else if (count_ff != '0) begin
			count_ff <= count_ff - W'(1);
		end
	end

	assign t.count = count_ff;
	assign t.zero  = (count_ff == '0);
endmodule : countdown_timer

// File: src/pci_arbiter_shared_fb_decode.sv
// PCI bus arbiter with host policy and the shared frame buffer address decode.
// Assumes one clock for PCI, host and memory arbitration, and a classic Wishbone master.
// Notes on behaviour
// - Four PCI masters on pairs 3:0 plus ISA bridge on hold request/acknowledge.
// - With shared buffer enabled, pair three carries graphics memory request and grant.
// - Scheme bit picks three grants (mode 0) or two (mode 1) before host.
// - Winner found in fixed ring starting at a movable top-priority pointer.
// - Only grants to a new agent count; grants inside one timer period count once.
// - Grant drops once FRAME# seen, or 16 clocks after grant if no cycle.
// - Each grant loads the multi-transaction timer, which counts down to zero.
// - While that timer runs, the last granted agent is top priority.
// - Host gets bus at top priority, or when PCI needs no memory nor lock.
// - Host latency timer holds off other PCI grants after a priority host grant.
// - Host handover is controlled through the processor address-hold output.
// - Shared buffer spans start address up to top of memory from row boundary four.
// - Memory hole is 15-16 MB for 1 MB size, 14-16 MB for 2 MB size.
// - With overlap on, hole wins and hole or buffer CPU cycles go to PCI.
// - CPU reaches all DRAM; buffer range is marked non-cacheable.
// - Control bit 0 sends aperture cycles to PCI when closed, DRAM when open.
// - CPU cycles in the relocatable frame buffer range go to PCI.
// - With shared buffer on, PCI memory cycles above top of memory are not claimed.
// - Bridge and graphics controller alternate driving DRAM, the idle side tri-states.
// - Memory request and grant run on the host clock on both sides.
// - Bridge parks on DRAM; request line signals low or high priority.
// - Low-priority graphics request served only with no CPU, PCI or refresh pending.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module pci_arbiter_shared_fb_decode (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// PCI arbitration
	input  wire logic [3:0]  pci_req_n_i,
	output logic      [3:0]  pci_gnt_n_o,
	input  wire logic        pci_frame_n_i,
	input  wire logic        pci_bus_idle_i,
	input  wire logic        pci_lock_i,
	input  wire logic        pci_mem_access_i,
	input  wire logic        isa_bridge_hold_req_n_i,
	output logic             isa_bridge_hold_ack_n_o,
	output logic             cpu_address_hold_o,
	// Shared DRAM arbitration
	input  wire logic        cpu_dram_req_i,
	input  wire logic        pci_dram_req_i,
	input  wire logic        refresh_hi_req_i,
	input  wire logic        dram_busy_i,
	output logic             bridge_dram_drive_o,
	// Address decode
	input  wire logic        cpu_cycle_i,
	input  wire logic [31:0] cpu_addr_i,
	output logic             cpu_to_pci_o,
	output logic             cpu_to_dram_o,
	output logic             cpu_noncacheable_o,
	input  wire logic        pci_mem_cycle_i,
	input  wire logic [31:0] pci_addr_i,
	output logic             pci_claim_o
);
	import arb_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0]     arbitration_control_reg_ff;
	logic [31:0]     shared_buffer_control_reg_ff;
	logic [MB_W-1:0] shared_buffer_start_addr_ff;
	logic [MB_W-1:0] row_boundary_four_ff;
	logic [MB_W-1:0] reloc_base_ff;
	logic [MB_W-1:0] reloc_limit_ff;
	logic [31:0]     rd_data;
	logic            wr_stb;
	logic [31:0]     status_word;
	logic            shared_frame_buffer_feature;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = dat[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign shared_frame_buffer_feature = shared_buffer_control_reg_ff[SB_ENABLE_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arbitration_control_reg_ff   <= ARB_CTRL_RST;
			shared_buffer_control_reg_ff <= SB_CTRL_RST;
			shared_buffer_start_addr_ff  <= MB_RST;
			row_boundary_four_ff         <= MB_RST;
			reloc_base_ff                <= MB_RST;
			reloc_limit_ff               <= MB_RST;
		end else if (wr_stb) begin
			case (wb_adr_i)
				ADR_ARB_CTRL: begin
					arbitration_control_reg_ff <= merge(arbitration_control_reg_ff, wb_dat_i, wb_sel_i);
				end
				ADR_SB_CTRL: begin
					shared_buffer_control_reg_ff <= merge(shared_buffer_control_reg_ff, wb_dat_i, wb_sel_i);
				end
				ADR_SB_START: begin
					shared_buffer_start_addr_ff <= MB_W'(merge(32'(shared_buffer_start_addr_ff), wb_dat_i, wb_sel_i));
				end
				ADR_ROW_BND4: begin
					row_boundary_four_ff <= MB_W'(merge(32'(row_boundary_four_ff), wb_dat_i, wb_sel_i));
				end
				ADR_RELOC_BASE: begin
					reloc_base_ff <= MB_W'(merge(32'(reloc_base_ff), wb_dat_i, wb_sel_i));
				end
				ADR_RELOC_LIM: begin
					reloc_limit_ff <= MB_W'(merge(32'(reloc_limit_ff), wb_dat_i, wb_sel_i));
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (wb_adr_i)
			ADR_ARB_CTRL:   rd_data = arbitration_control_reg_ff;
			ADR_SB_CTRL:    rd_data = shared_buffer_control_reg_ff;
			ADR_SB_START:   rd_data = 32'(shared_buffer_start_addr_ff);
			ADR_ROW_BND4:   rd_data = 32'(row_boundary_four_ff);
			ADR_RELOC_BASE: rd_data = 32'(reloc_base_ff);
			ADR_RELOC_LIM:  rd_data = 32'(reloc_limit_ff);
			ADR_STATUS:     rd_data = status_word;
			default:        rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
			wb_dat_o <= rd_data;
		end
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	countdown_if #(.W(TMR_W)) multi_transaction_timer ();
	countdown_if #(.W(TMR_W)) host_latency_timer ();
	countdown_if #(.W(GTO_W)) grant_timeout ();

	countdown_timer #(.W(TMR_W)) u_mtt (.clk_i(clk_i), .rst_i(rst_i), .t(multi_transaction_timer));
	countdown_timer #(.W(TMR_W)) u_hlt (.clk_i(clk_i), .rst_i(rst_i), .t(host_latency_timer));
	countdown_timer #(.W(GTO_W)) u_gto (.clk_i(clk_i), .rst_i(rst_i), .t(grant_timeout));

	// ----------------------------------------------------------------
	// PCI arbitration
	// ----------------------------------------------------------------
	arb_state_t  state_ff;
	logic [4:0]  grant_ff;
	logic [2:0]  ptr_ff;
	logic [2:0]  last_ff;
	logic [1:0]  grant_cnt_ff;
	logic        host_due_ff;
	logic        hold_ff;
	logic [4:0]  reqs;
	logic [2:0]  search_top;
	logic [2:0]  winner;
	logic        any_req;
	logic        do_grant;
	logic        new_agent;
	logic [1:0]  host_after;

	assign reqs = {~isa_bridge_hold_req_n_i, ~pci_req_n_i[3] & ~shared_frame_buffer_feature, ~pci_req_n_i[2:0]};
	assign search_top = multi_transaction_timer.zero ? ptr_ff : last_ff;

	always_comb begin
		logic [2:0] idx;
		idx     = search_top;
		winner  = search_top;
		any_req = 1'b0;
		for (int i = 0; i < N_AGENTS; i++) begin
			if (!any_req && reqs[idx]) begin
				winner  = idx;
				any_req = 1'b1;
			end
			idx = (idx == AGENT_LAST) ? 3'h0 : idx + 3'h1;
		end
	end

	assign host_after = arbitration_control_reg_ff[ARB_SCHEME_BIT] ? HOST_AFTER_MODE1 : HOST_AFTER_MODE0;
	assign do_grant   = (state_ff == ST_IDLE) && !host_due_ff && any_req;
	assign new_agent  = (winner != last_ff) && multi_transaction_timer.zero;

	assign multi_transaction_timer.load   = do_grant;
	assign multi_transaction_timer.preset = arbitration_control_reg_ff[MTT_LSB +: TMR_W];
	assign grant_timeout.load             = do_grant;
	assign grant_timeout.preset           = GNT_TIMEOUT_PRESET;
	assign host_latency_timer.load        = (state_ff == ST_IDLE) && host_due_ff;
	assign host_latency_timer.preset      = arbitration_control_reg_ff[HLT_LSB +: TMR_W];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_IDLE;
			grant_ff <= 5'h00;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (host_due_ff) begin
						state_ff <= ST_HOST;
					end else if (any_req) begin
						state_ff <= ST_GRANT;
						grant_ff <= 5'(1) << winner;
					end
				end
				ST_GRANT: begin
					if (grant_ff[AGENT_ISA]) begin
						if (isa_bridge_hold_req_n_i) begin
							state_ff <= ST_IDLE;
							grant_ff <= 5'h00;
						end
					end else if (!pci_frame_n_i) begin
						state_ff <= ST_BUSY;
						grant_ff <= 5'h00;
					end else if (grant_timeout.zero) begin
						state_ff <= ST_IDLE;
						grant_ff <= 5'h00;
					end
				end
				ST_BUSY: begin
					if (pci_bus_idle_i && pci_frame_n_i) begin
						state_ff <= ST_IDLE;
					end
				end
				ST_HOST: begin
					if (host_latency_timer.zero) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					grant_ff <= 5'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_ff  <= 3'h0;
			last_ff <= 3'h0;
		end else if (do_grant) begin
			last_ff <= winner;
			ptr_ff  <= (winner == AGENT_LAST) ? 3'h0 : winner + 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grant_cnt_ff <= 2'h0;
			host_due_ff  <= 1'b0;
		end else if (host_latency_timer.load) begin
			host_due_ff <= 1'b0;
		end else if (do_grant && new_agent) begin
			if (grant_cnt_ff + 2'h1 == host_after) begin
				grant_cnt_ff <= 2'h0;
				host_due_ff  <= 1'b1;
			end else begin
				grant_cnt_ff <= grant_cnt_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_ff <= 1'b0;
		end else begin
			hold_ff <= (state_ff == ST_GRANT || state_ff == ST_BUSY) && (pci_mem_access_i || pci_lock_i);
		end
	end
	assign cpu_address_hold_o = hold_ff;

	// ----------------------------------------------------------------
	// Graphics memory arbitration
	// ----------------------------------------------------------------
	gfx_state_t gfx_state_ff;
	logic       gfx_gap_ff;
	logic       gfx_hipri_ff;
	logic       gfx_own_ff;
	logic       gfx_memory_request_n;
	logic       gfx_memory_grant_n;
	logic       gfx_may_grant;

	assign gfx_memory_request_n = pci_req_n_i[3] | ~shared_frame_buffer_feature;
	assign gfx_may_grant = !dram_busy_i && (gfx_hipri_ff || !(cpu_dram_req_i || pci_dram_req_i || refresh_hi_req_i));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gfx_state_ff <= GFX_PARK;
			gfx_gap_ff   <= 1'b0;
			gfx_hipri_ff <= 1'b0;
		end else begin
			case (gfx_state_ff)
				GFX_PARK: begin
					gfx_gap_ff   <= 1'b0;
					gfx_hipri_ff <= 1'b0;
					if (!gfx_memory_request_n) begin
						gfx_state_ff <= GFX_PEND;
					end
				end
				GFX_PEND: begin
					if (gfx_memory_request_n) begin
						gfx_gap_ff <= 1'b1;
						if (gfx_gap_ff) begin
							gfx_state_ff <= GFX_PARK;
						end
					end else if (gfx_gap_ff) begin
						gfx_gap_ff   <= 1'b0;
						gfx_hipri_ff <= 1'b1;
					end else if (gfx_may_grant) begin
						gfx_state_ff <= GFX_OWN;
					end
				end
				GFX_OWN: begin
					if (gfx_memory_request_n) begin
						gfx_state_ff <= GFX_PARK;
					end
				end
				default: begin
					gfx_state_ff <= GFX_PARK;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gfx_own_ff <= 1'b0;
		end else begin
			gfx_own_ff <= (gfx_state_ff == GFX_PEND && !gfx_memory_request_n && !gfx_gap_ff && gfx_may_grant)
				|| (gfx_state_ff == GFX_OWN && !gfx_memory_request_n);
		end
	end
	assign gfx_memory_grant_n  = ~gfx_own_ff;
	assign bridge_dram_drive_o = ~gfx_own_ff;

	assign pci_gnt_n_o[2:0]        = ~grant_ff[2:0];
	assign pci_gnt_n_o[3]          = shared_frame_buffer_feature ? gfx_memory_grant_n : ~grant_ff[AGENT_GFX];
	assign isa_bridge_hold_ack_n_o = ~grant_ff[AGENT_ISA];

	assign status_word = {16'h0000, 6'h00, grant_cnt_ff, 1'b0, gfx_own_ff, 1'b0, grant_ff};

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic [MB_W-1:0] cpu_mb;
	logic [MB_W-1:0] pci_mb;
	logic [MB_W-1:0] hole_bot;
	logic            cpu_high;
	logic            pci_high;
	logic            in_hole;
	logic            in_fb;
	logic            in_reloc;
	logic            to_pci;

	assign cpu_mb   = cpu_addr_i[MB_LSB +: MB_W];
	assign pci_mb   = pci_addr_i[MB_LSB +: MB_W];
	assign cpu_high = cpu_mb >= row_boundary_four_ff;
	assign pci_high = pci_mb >= row_boundary_four_ff;
	assign hole_bot = shared_buffer_control_reg_ff[SB_HOLE_2MB_BIT] ? HOLE_2MB_BOT : HOLE_1MB_BOT;
	assign in_hole  = shared_buffer_control_reg_ff[SB_HOLE_EN_BIT] && cpu_mb >= hole_bot && cpu_mb < HOLE_TOP_MB;
	assign in_fb    = shared_frame_buffer_feature && cpu_mb >= shared_buffer_start_addr_ff && !cpu_high;
	assign in_reloc = shared_buffer_control_reg_ff[SB_RELOC_EN_BIT] && cpu_mb >= reloc_base_ff
		&& cpu_mb <= reloc_limit_ff;
	assign to_pci   = in_hole || in_reloc || cpu_high
		|| (in_fb && (!shared_buffer_control_reg_ff[SB_APERTURE_BIT] || shared_buffer_control_reg_ff[SB_OVERLAP_BIT]));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_to_pci_o       <= 1'b0;
			cpu_to_dram_o      <= 1'b0;
			cpu_noncacheable_o <= 1'b0;
		end else begin
			cpu_to_pci_o       <= cpu_cycle_i && to_pci;
			cpu_to_dram_o      <= cpu_cycle_i && !to_pci;
			cpu_noncacheable_o <= cpu_cycle_i && in_fb;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pci_claim_o <= 1'b0;
		end else begin
			pci_claim_o <= pci_mem_cycle_i && !(pci_high && shared_frame_buffer_feature);
		end
	end

endmodule : pci_arbiter_shared_fb_decode

// File: bench/arb_properties.sv
// Concurrent checks on the arbiter and decode top-level ports.
// Assumes it is bound into pci_arbiter_shared_fb_decode and sees only its ports.
`timescale 1ns/10ps
module arb_properties (
	// Clock, reset and bus
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// Arbitration and decode
	input wire logic [3:0] pci_gnt_n_o,
	input wire logic       pci_frame_n_i,
	input wire logic       pci_lock_i,
	input wire logic       pci_mem_access_i,
	input wire logic       isa_bridge_hold_req_n_i,
	input wire logic       isa_bridge_hold_ack_n_o,
	input wire logic       cpu_address_hold_o,
	input wire logic       cpu_cycle_i,
	input wire logic       cpu_to_pci_o,
	input wire logic       cpu_to_dram_o,
	input wire logic       pci_mem_cycle_i,
	input wire logic       pci_claim_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_one_grant:
		assert property ($onehot0({~pci_gnt_n_o, ~isa_bridge_hold_ack_n_o})) else $error("two grants at once");
	chk_reset_idle:
		assert property ($past(rst_i) |-> pci_gnt_n_o == 4'hf && isa_bridge_hold_ack_n_o) else $error("grant out of reset");
	chk_ack_answer:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus cycle not answered");
	chk_ack_pulse:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	chk_frame_drop:
		assert property (pci_gnt_n_o[2:0] != 3'h7 && !pci_frame_n_i |-> ##[1:2] pci_gnt_n_o[2:0] == 3'h7)
			else $error("grant kept after cycle start");
	chk_gnt_timeout:
		assert property ($fell(pci_gnt_n_o[1]) |-> ##[1:16] pci_gnt_n_o[1]) else $error("grant over 16 cycles");
	chk_isa_stands:
		assert property (!isa_bridge_hold_ack_n_o && !isa_bridge_hold_req_n_i |=> !isa_bridge_hold_ack_n_o)
			else $error("hold ack dropped early");
	chk_hold_cause:
		assert property ($rose(cpu_address_hold_o) |-> $past(pci_mem_access_i || pci_lock_i)
			|| $past(pci_mem_access_i || pci_lock_i, 2)) else $error("address hold without cause");
	chk_route_one:
		assert property ((cpu_to_pci_o || cpu_to_dram_o) == $past(cpu_cycle_i) && !(cpu_to_pci_o && cpu_to_dram_o))
			else $error("cpu cycle not routed once");
	chk_claim_cause:
		assert property (pci_claim_o |-> $past(pci_mem_cycle_i)) else $error("claim without cycle");
endmodule : arb_properties
bind pci_arbiter_shared_fb_decode arb_properties arb_properties_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .pci_gnt_n_o, .pci_frame_n_i, .pci_lock_i, .pci_mem_access_i, .isa_bridge_hold_req_n_i,
	.isa_bridge_hold_ack_n_o, .cpu_address_hold_o, .cpu_cycle_i, .cpu_to_pci_o, .cpu_to_dram_o,
	.pci_mem_cycle_i, .pci_claim_o);

// File: bench/pci_master_model.sv
// Behavioural PCI masters and graphics request line on the arbiter's far side.
// Assumes the bench sets which agents request; FRAME# has a pull-up, so it idles high.
`timescale 1ns/10ps
module pci_master_model (
	// Clock, reset and bench control
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] want_i,
	input  wire logic       slow_i,
	// Arbitration wires
	input  wire logic [3:0] gnt_n_i,
	output logic      [3:0] req_n_o,
	output logic            frame_n_o,
	output logic            bus_idle_o
);
	logic [1:0] busy_ff;
	// requests are levels on the shared clock
	assign req_n_o = ~want_i;
	// a master granted on pairs 2:0 starts its cycle, unless told to stall
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff <= 2'h0;
		end else if (busy_ff != 2'h0) begin
			busy_ff <= busy_ff - 2'h1;
		end else if (gnt_n_i[2:0] != 3'h7 && !slow_i) begin
			busy_ff <= 2'h3;
		end
	end
	assign frame_n_o  = (busy_ff != 2'h3);
	assign bus_idle_o = (busy_ff == 2'h0);
endmodule : pci_master_model

// File: bench/pci_arbiter_shared_fb_decode_tb_top.sv
// Self-checking bench for the arbiter and shared buffer decode.
// Assumes the master model on the PCI side and a Wishbone master here.
`timescale 1ns/10ps
module pci_arbiter_shared_fb_decode_tb_top;
	import arb_pkg::*;
	localparam logic [11:0] START = 12'h00d;
	localparam logic [11:0] RB4   = 12'h010;
	localparam logic [11:0] RELOC = 12'h01f;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, pci_frame_n_i, pci_bus_idle_i;
	logic pci_lock_i = 0, pci_mem_access_i = 0, isa_bridge_hold_req_n_i = 1, slow = 0, dram_busy_i = 0;
	logic cpu_dram_req_i = 0, pci_dram_req_i = 0, refresh_hi_req_i = 0, cpu_cycle_i = 0, pci_mem_cycle_i = 0;
	logic wb_ack_o, isa_bridge_hold_ack_n_o, cpu_address_hold_o, bridge_dram_drive_o;
	logic cpu_to_pci_o, cpu_to_dram_o, cpu_noncacheable_o, pci_claim_o;
	logic [3:0]  wb_sel_i = 4'hf, want = 4'h0, pci_req_n_i, pci_gnt_n_o;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 0, cpu_addr_i = 0, pci_addr_i = 0, wb_dat_o, rd, seed = 32'd14655;
	int          bad_count = 0, compares = 0;
	pci_arbiter_shared_fb_decode pci_arbiter_shared_fb_decode_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pci_req_n_i, .pci_gnt_n_o,
		.pci_frame_n_i, .pci_bus_idle_i, .pci_lock_i, .pci_mem_access_i, .isa_bridge_hold_req_n_i,
		.isa_bridge_hold_ack_n_o, .cpu_address_hold_o, .cpu_dram_req_i, .pci_dram_req_i, .refresh_hi_req_i,
		.dram_busy_i, .bridge_dram_drive_o, .cpu_cycle_i, .cpu_addr_i, .cpu_to_pci_o, .cpu_to_dram_o,
		.cpu_noncacheable_o, .pci_mem_cycle_i, .pci_addr_i, .pci_claim_o);
	pci_master_model pci_master_model_i (.clk_i, .rst_i, .want_i(want), .slow_i(slow),
		.gnt_n_i(pci_gnt_n_o), .req_n_o(pci_req_n_i), .frame_n_o(pci_frame_n_i), .bus_idle_o(pci_bus_idle_i));
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Expected {to_pci, to_dram, noncacheable, claim} with the feature on.
	function automatic logic [3:0] route(input logic [31:0] a, input logic [5:0] c);
		logic [11:0] m;
		logic        hole, buff, pci;
		m    = a[31:20];
		hole = c[SB_HOLE_EN_BIT] && m < HOLE_TOP_MB && m >= (c[SB_HOLE_2MB_BIT] ? HOLE_2MB_BOT : HOLE_1MB_BOT);
		buff = m >= START && m < RB4;
		pci  = hole || (c[SB_RELOC_EN_BIT] && m == RELOC) || m >= RB4;
		pci  = pci || (buff && (!c[SB_APERTURE_BIT] || c[SB_OVERLAP_BIT]));
		return {pci, !pci, buff, m < RB4};
	endfunction : route
	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic lim(input int n);
		if (n >= 60) begin
			bad_count++;
			$display("ERROR %0t: wait ran out", $time);
			final_report();
		end
	endtask : lim
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 60);
		lim(n);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic grant_one(input logic [3:0] w, input logic [3:0] e);
		int          n;
		logic [31:0] r;
		r = xs();
		pci_lock_i       <= r[0];
		pci_mem_access_i <= r[1];
		want             <= w;
		for (n = 0; n < 60 && pci_gnt_n_o === 4'hf; n++) @(posedge clk_i);
		lim(n);
		chk(32'(pci_gnt_n_o), 32'(e));
		for (n = 0; n < 60 && pci_frame_n_i !== 1'b0; n++) @(posedge clk_i);
		lim(n);
		chk(32'(cpu_address_hold_o), 32'(r[0] | r[1]));
		want <= 4'h0;
		repeat (2) @(posedge clk_i);
		chk(32'(pci_gnt_n_o), 32'hf);
	endtask : grant_one
	initial begin
		int          n, i, k;
		logic [31:0] a;
		logic [5:0]  c;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, ADR_ARB_CTRL, 32'h0);
		chk(rd, ARB_CTRL_RST);
		wb(1'b0, ADR_SB_CTRL, 32'h0);
		chk(rd, SB_CTRL_RST);
		wb(1'b1, 8'h1c, 32'hffff_ffff);
		wb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h0);
		for (i = 0; i < 4; i++) begin
			a = xs() & 32'h0000_0fff;
			wb(1'b1, ADR_SB_START + 8'(4 * i), a);
			wb(1'b0, ADR_SB_START + 8'(4 * i), 32'h0);
			chk(rd, a);
		end
		a = ARB_CTRL_RST | (xs() & 32'h1);
		wb(1'b1, ADR_ARB_CTRL, a);
		wb(1'b0, ADR_ARB_CTRL, 32'h0);
		chk(rd, a);
		for (i = 0; i < 3; i++) grant_one(4'h1 << i, ~(4'h1 << i));
		grant_one(4'h2, 4'hd);
		grant_one(4'h3, 4'hd);
		repeat (30) @(posedge clk_i);
		grant_one(4'h3, 4'he);
		slow <= 1'b1;
		want <= 4'h2;
		for (n = 0; n < 60 && pci_gnt_n_o === 4'hf; n++) @(posedge clk_i);
		lim(n);
		for (n = 0; n < 60 && pci_gnt_n_o[1] === 1'b0; n++) @(posedge clk_i);
		want <= 4'h0;
		slow <= 1'b0;
		chk(32'(n), 32'(GNT_TIMEOUT_PCLKS));
		isa_bridge_hold_req_n_i <= 1'b0;
		for (n = 0; n < 60 && isa_bridge_hold_ack_n_o !== 1'b0; n++) @(posedge clk_i);
		lim(n);
		repeat (5) @(posedge clk_i);
		chk(32'(isa_bridge_hold_ack_n_o), 32'h0);
		isa_bridge_hold_req_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(32'(isa_bridge_hold_ack_n_o), 32'h1);
		wb(1'b1, ADR_SB_CTRL, 32'h2);
		a = xs();
		cpu_dram_req_i   <= a[0];
		refresh_hi_req_i <= !a[0];
		pci_dram_req_i   <= a[1];
		want             <= 4'h8;
		repeat (6) @(posedge clk_i);
		chk(32'({pci_gnt_n_o[3], bridge_dram_drive_o}), 32'h3);
		cpu_dram_req_i   <= 1'b0;
		refresh_hi_req_i <= 1'b0;
		pci_dram_req_i   <= 1'b0;
		for (n = 0; n < 60 && pci_gnt_n_o[3] !== 1'b0; n++) @(posedge clk_i);
		lim(n);
		repeat (2) @(posedge clk_i);
		chk(32'({pci_gnt_n_o, bridge_dram_drive_o}), 32'h0e);
		want <= 4'h0;
		repeat (3) @(posedge clk_i);
		chk(32'({pci_gnt_n_o[3], bridge_dram_drive_o}), 32'h3);
		wb(1'b1, ADR_SB_START, 32'(START));
		wb(1'b1, ADR_ROW_BND4, 32'(RB4));
		wb(1'b1, ADR_RELOC_BASE, 32'(RELOC));
		wb(1'b1, ADR_RELOC_LIM, 32'(RELOC));
		for (k = 0; k < 8; k++) begin
			c = {1'b1, k[2], 1'b1, k[1], 1'b1, k[0]};
			wb(1'b1, ADR_SB_CTRL, {26'h0, c});
			for (n = 0; n < 40; n++) begin
				a = (n < 8) ? 32'(n + 12) << 20 : xs() & 32'h01ff_ffff;
				cpu_addr_i      <= a;
				pci_addr_i      <= a;
				cpu_cycle_i     <= 1'b1;
				pci_mem_cycle_i <= 1'b1;
				repeat (2) @(posedge clk_i);
				chk(32'({cpu_to_pci_o, cpu_to_dram_o, cpu_noncacheable_o, pci_claim_o}), 32'(route(a, c)));
			end
		end
		final_report();
	end
endmodule : pci_arbiter_shared_fb_decode_tb_top
